// ==== rtl/tmr_pkg.sv ====
// Constants for the eight-bit timer/counter core with two compare units.
// Assumes an APB slave with 32-bit data and byte addresses on paddr.
package tmr_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A  = 8'h00;
  localparam logic [7:0] OFS_CTRL_B  = 8'h04;
  localparam logic [7:0] OFS_CTRL_C  = 8'h08;
  localparam logic [7:0] OFS_COUNT   = 8'h0c;
  localparam logic [7:0] OFS_CMP_A   = 8'h10;
  localparam logic [7:0] OFS_CMP_B   = 8'h14;
  localparam logic [7:0] OFS_FLAG    = 8'h18;
  localparam logic [7:0] OFS_MASK    = 8'h1c;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int POS_COM_A   = 6;   // ctrl_a[7:6]
  localparam int POS_COM_B   = 4;   // ctrl_a[5:4]
  localparam int POS_WAVE_LO = 0;   // ctrl_a[1:0]
  localparam int POS_WAVE_HI = 3;   // ctrl_b[3]
  localparam int POS_CS      = 0;   // ctrl_b[2:0]
  localparam int POS_FORCE_A = 7;   // ctrl_c[7]
  localparam int POS_FORCE_B = 6;   // ctrl_c[6]
  localparam int POS_OVF     = 0;   // flag / mask bit
  localparam int POS_MATCH_A = 1;
  localparam int POS_MATCH_B = 2;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP   = 8'h00;
  localparam logic [2:0] RST_FLAG  = 3'h0;

  // ------------------------------------------------------------------
  // Tick sources, CTC wave mode and compare output actions
  // ------------------------------------------------------------------
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_PCLK     = 3'h1;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [2:0] WAVE_CTC    = 3'h2;
  localparam logic [1:0] COM_NONE    = 2'h0;
  localparam logic [1:0] COM_TOGGLE  = 2'h1;
  localparam logic [1:0] COM_CLEAR   = 2'h2;
  localparam logic [1:0] COM_SET     = 2'h3;

endpackage : tmr_pkg

// ==== rtl/tmr_cmp_if.sv ====
// Bundle between the counter core and one compare unit.
// Assumes both sides run on the same pclk.
interface tmr_cmp_if #(parameter int W = 8);
  logic [W-1:0] cnt;          // Live counter value
  logic         wr_en;        // CPU write to this compare register
  logic [W-1:0] wr_data;      // Write data
  logic         pwm;          // Double buffering active
  logic         load;         // Copy buffer to active register
  logic         tick_ok;      // Tick with matches not blocked
  logic         force_cmp;    // Forced match strobe
  logic [1:0]   com;          // Compare output mode
  logic         fast;         // Single-slope PWM
  logic         count_up;     // Direction for dual slope
  logic         bottom_evt;   // Fast PWM wrap to bottom
  logic [W-1:0] ocr;          // Active compare value
  logic [W-1:0] buf_val;      // Buffer seen by the CPU
  logic         match;        // Counter equals active value
  logic         oc_state;     // Internal compare output state

  modport unit (
    input  cnt, wr_en, wr_data, pwm, load, tick_ok, force_cmp,
    input  com, fast, count_up, bottom_evt,
    output ocr, buf_val, match, oc_state
  );
  modport core (
    output cnt, wr_en, wr_data, pwm, load, tick_ok, force_cmp,
    output com, fast, count_up, bottom_evt,
    input  ocr, buf_val, match, oc_state
  );
endinterface : tmr_cmp_if

// ==== rtl/tmr_cmp_unit.sv ====
// One compare unit: buffered compare value and output state.
// Assumes the core qualifies ticks, forces and loads.
module tmr_cmp_unit #(
  parameter int W = 8
) (
  input wire logic pclk,          // System clock
  input wire logic presetn,       // Async reset, active low
  tmr_cmp_if.unit  bus            // Link to the counter core
);

  logic [W-1:0] ocr_reg;
  logic [W-1:0] buf_reg;
  logic         oc_reg;
  logic         oc_next;
  logic         evt;

  assign bus.ocr     = ocr_reg;
  assign bus.buf_val = buf_reg;
  assign bus.match   = (bus.cnt == ocr_reg);
  assign bus.oc_state = oc_reg;
  assign evt = bus.tick_ok & bus.match;

  // ------------------------------------------------------------------
  // Compare value and its buffer
  // ------------------------------------------------------------------
  // Buffer always takes CPU writes; active copy only when unbuffered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ocr_reg <= W'(tmr_pkg::RST_CMP);
      buf_reg <= W'(tmr_pkg::RST_CMP);
    end
    else
    begin
      if (bus.wr_en)
        buf_reg <= bus.wr_data;
      if (bus.wr_en && !bus.pwm)
        ocr_reg <= bus.wr_data;
      else if (bus.pwm && bus.load)
        ocr_reg <= buf_reg;
    end
  end

  // ------------------------------------------------------------------
  // Output state action
  // ------------------------------------------------------------------
  // Mode field read live, so a change acts at once
  always_comb
  begin
    oc_next = oc_reg;
    if (!bus.pwm)
    begin
      if (evt || bus.force_cmp)
      begin
        unique case (bus.com)
          tmr_pkg::COM_NONE:   oc_next = oc_reg;
          tmr_pkg::COM_TOGGLE: oc_next = ~oc_reg;
          tmr_pkg::COM_CLEAR:  oc_next = 1'b0;
          tmr_pkg::COM_SET:    oc_next = 1'b1;
        endcase
      end
    end
    else if (bus.com[1])
    begin
      // Inverting when the low bit is set
      if (bus.fast)
      begin
        if (bus.bottom_evt)
          oc_next = ~bus.com[0];
        else if (evt)
          oc_next = bus.com[0];
      end
      else if (evt)
        oc_next = bus.count_up ? bus.com[0] : ~bus.com[0];
    end
  end

  // Held across mode changes; only compare actions and reset change it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oc_reg <= 1'b0;
    else
      oc_reg <= oc_next;
  end

endmodule : tmr_cmp_unit

// ==== rtl/tmr_core.sv ====
// Eight-bit timer/counter core with two compare units, APB registers.
// Assumes prescaler taps are pclk-domain pulses; count pin is async.
//
// Implementation choices: the address map and the APB interface to the registers.
module tmr_core #(
  parameter int W = 8               // Counter width
) (
  input  wire logic        pclk,          // System clock, 10 MHz
  input  wire logic        presetn,       // Async reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB access phase
  input  wire logic        pwrite,        // APB write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // Always ready
  output logic             pslverr,       // Unmapped address
  input  wire logic [3:0]  presc_tap,     // Prescaler tick pulses
  input  wire logic        ext_count_pin, // External count input
  input  wire logic [2:0]  irq_ack,       // Interrupt taken pulses
  output logic      [2:0]  irq_req,       // Masked interrupt levels
  input  wire logic        port_out_a,    // Port value under A
  input  wire logic        port_dir_a,    // Port direction under A
  input  wire logic        port_out_b,    // Port value under B
  input  wire logic        port_dir_b,    // Port direction under B
  output logic             cmp_output_a,  // Pin A value
  output logic             cmp_output_a_oe, // Pin A drive enable
  output logic             cmp_output_b,  // Pin B value
  output logic             cmp_output_b_oe  // Pin B drive enable
);

  // Elaboration refuses widths the logic cannot serve
  if (W < 2 || W > 8)
  begin : g_bad_width
    $error("counter width must be 2 to 8");
  end

  localparam logic [W-1:0] MAXV = {W{1'b1}};
  localparam logic [W-1:0] BOTV = '0;
  localparam logic [W-1:0] ONE  = W'(1);

  // ------------------------------------------------------------------
  // Registers and wires
  // ------------------------------------------------------------------
  logic [7:0]   ctrl_a_reg;
  logic [3:0]   ctrl_b_reg;
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         dir_up_reg;
  logic         dir_up_next;
  logic         block_reg;
  logic [2:0]   flag_reg;
  logic [2:0]   flag_next;
  logic [2:0]   mask_reg;
  logic [31:0]  prdata_reg;
  logic [2:0]   ext_sync_reg;
  logic         tick;
  logic         tick_ok;
  logic [2:0]   wave_mode_field;
  logic [2:0]   tick_source_select;
  logic         pwm;
  logic         fast;
  logic         use_a_top;
  logic [W-1:0] top_val;
  logic         at_top;
  logic         at_bottom;
  logic         ovf_evt;
  logic         wr_acc;
  logic         rd_setup;
  logic         addr_ok;
  logic         wr_count;
  logic [1:0]   force_cmp;
  logic [1:0]   match_evt;

  tmr_cmp_if #(.W(W)) cif[2] ();

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign addr_ok  = (paddr[1:0] == 2'b00) && (paddr < 8'h20);
  assign wr_acc   = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;
  assign prdata   = prdata_reg;
  assign wr_count = wr_acc && (paddr == tmr_pkg::OFS_COUNT);

  assign wave_mode_field = {ctrl_b_reg[tmr_pkg::POS_WAVE_HI],
                            ctrl_a_reg[tmr_pkg::POS_WAVE_LO +: 2]};
  assign tick_source_select = ctrl_b_reg[tmr_pkg::POS_CS +: 3];

  // Force strobes only count outside PWM; never stored
  assign force_cmp[0] = wr_acc && (paddr == tmr_pkg::OFS_CTRL_C)
                        && pwdata[tmr_pkg::POS_FORCE_A] && !pwm;
  assign force_cmp[1] = wr_acc && (paddr == tmr_pkg::OFS_CTRL_C)
                        && pwdata[tmr_pkg::POS_FORCE_B] && !pwm;

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a_reg <= tmr_pkg::RST_CTRL;
      ctrl_b_reg <= tmr_pkg::RST_CTRL[3:0];
      mask_reg   <= tmr_pkg::RST_FLAG;
    end
    else if (wr_acc)
    begin
      if (paddr == tmr_pkg::OFS_CTRL_A)
        ctrl_a_reg <= pwdata[7:0];
      if (paddr == tmr_pkg::OFS_CTRL_B)
        ctrl_b_reg <= pwdata[3:0];
      if (paddr == tmr_pkg::OFS_MASK)
        mask_reg <= pwdata[2:0];
    end
  end

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Sampled in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0000_0000;
    else if (rd_setup)
    begin
      unique case (paddr)
        tmr_pkg::OFS_CTRL_A: prdata_reg <= {24'h00_0000, ctrl_a_reg};
        tmr_pkg::OFS_CTRL_B: prdata_reg <= {28'h000_0000, ctrl_b_reg};
        tmr_pkg::OFS_COUNT:  prdata_reg <= 32'(count_reg);
        tmr_pkg::OFS_CMP_A:  prdata_reg <= 32'(cif[0].buf_val);
        tmr_pkg::OFS_CMP_B:  prdata_reg <= 32'(cif[1].buf_val);
        tmr_pkg::OFS_FLAG:   prdata_reg <= {29'h0, flag_reg};
        tmr_pkg::OFS_MASK:   prdata_reg <= {29'h0, mask_reg};
        default:             prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Tick selection
  // ------------------------------------------------------------------
  // Two flops before any logic; the third only serves edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_sync_reg <= 3'h0;
    else
      ext_sync_reg <= {ext_sync_reg[1:0], ext_count_pin};
  end

  always_comb
  begin
    tick = 1'b0;
    unique case (tick_source_select)
      tmr_pkg::CS_STOP:     tick = 1'b0;
      tmr_pkg::CS_PCLK:     tick = 1'b1;
      tmr_pkg::CS_EXT_FALL: tick = ext_sync_reg[2] && !ext_sync_reg[1];
      tmr_pkg::CS_EXT_RISE: tick = !ext_sync_reg[2] && ext_sync_reg[1];
      default:
        tick = presc_tap[2'(tick_source_select - 3'h2)];
    endcase
  end

  // ------------------------------------------------------------------
  // Mode decode, top and bottom
  // ------------------------------------------------------------------
  // Modes 4 and 6 are reserved and count like normal mode
  assign pwm       = wave_mode_field[0];
  assign fast      = wave_mode_field[0] && wave_mode_field[1];
  assign use_a_top = (wave_mode_field == tmr_pkg::WAVE_CTC)
                     || (wave_mode_field[2] && wave_mode_field[0]);
  assign top_val   = use_a_top ? cif[0].ocr : MAXV;
  assign at_top    = (count_reg == top_val);
  assign at_bottom = (count_reg == BOTV);
  assign tick_ok   = tick && !block_reg;

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  always_comb
  begin
    count_next  = count_reg;
    dir_up_next = dir_up_reg;
    ovf_evt     = 1'b0;
    if (wr_count)
      count_next = pwdata[W-1:0];
    else if (tick)
    begin
      if (pwm && !fast)
      begin
        // Dual slope: turn at top, turn again at bottom
        if (dir_up_reg)
        begin
          count_next  = at_top ? count_reg - ONE : count_reg + ONE;
          dir_up_next = !at_top;
        end
        else
        begin
          count_next  = at_bottom ? count_reg + ONE : count_reg - ONE;
          dir_up_next = at_bottom;
          ovf_evt     = at_bottom;
        end
      end
      else if (fast || use_a_top)
      begin
        count_next = at_top ? BOTV : count_reg + ONE;
        ovf_evt    = fast ? at_top : (count_reg == MAXV);
      end
      else
      begin
        count_next = count_reg + ONE;
        ovf_evt    = (count_reg == MAXV);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_reg  <= W'(tmr_pkg::RST_COUNT);
      dir_up_reg <= 1'b1;
    end
    else
    begin
      count_reg  <= count_next;
      dir_up_reg <= pwm ? dir_up_next : 1'b1;
    end
  end

  // Block lasts until the next tick, even while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_reg <= 1'b0;
    else if (wr_count)
      block_reg <= 1'b1;
    else if (tick)
      block_reg <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Compare units
  // ------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_cmp
    assign cif[i].cnt       = count_reg;
    assign cif[i].wr_en     = wr_acc && (paddr == (i == 0 ?
                              tmr_pkg::OFS_CMP_A : tmr_pkg::OFS_CMP_B));
    assign cif[i].wr_data   = pwdata[W-1:0];
    assign cif[i].pwm       = pwm;
    // Dual slope loads at top, single slope at bottom
    assign cif[i].load      = tick && (fast ? at_top
                              : (dir_up_reg && at_top));
    assign cif[i].tick_ok   = tick_ok;
    assign cif[i].force_cmp = force_cmp[i];
    assign cif[i].com       = ctrl_a_reg[(i == 0 ? tmr_pkg::POS_COM_A
                              : tmr_pkg::POS_COM_B) +: 2];
    assign cif[i].fast       = fast;
    assign cif[i].count_up   = dir_up_reg;
    assign cif[i].bottom_evt = tick && at_top;
    assign match_evt[i]      = tick_ok && cif[i].match;

    tmr_cmp_unit #(.W(W)) u_cmp (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (cif[i].unit)
    );
  end

  // ------------------------------------------------------------------
  // Interrupt flags
  // ------------------------------------------------------------------
  // Set beats clear so an event in the clearing cycle survives
  always_comb
  begin
    flag_next = flag_reg & ~irq_ack;
    if (wr_acc && (paddr == tmr_pkg::OFS_FLAG))
      flag_next = flag_next & ~pwdata[2:0];
    if (ovf_evt)
      flag_next[tmr_pkg::POS_OVF] = 1'b1;
    if (match_evt[0])
      flag_next[tmr_pkg::POS_MATCH_A] = 1'b1;
    if (match_evt[1])
      flag_next[tmr_pkg::POS_MATCH_B] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= tmr_pkg::RST_FLAG;
    else
      flag_reg <= flag_next;
  end

  assign irq_req = flag_reg & mask_reg;

  // ------------------------------------------------------------------
  // Pin override
  // ------------------------------------------------------------------
  // Direction stays with the port; only the value is replaced
  assign cmp_output_a    = (cif[0].com != tmr_pkg::COM_NONE)
                           ? cif[0].oc_state : port_out_a;
  assign cmp_output_b    = (cif[1].com != tmr_pkg::COM_NONE)
                           ? cif[1].oc_state : port_out_b;
  assign cmp_output_a_oe = port_dir_a;
  assign cmp_output_b_oe = port_dir_b;

endmodule : tmr_core

// ==== bench/tmr_core_properties.sv ====
// Port-level assertions for the timer core.
// Assumes zero-wait APB; writes land at the access edge.
module tmr_chk (
  input wire logic        pclk,            // Clock
  input wire logic        presetn,         // Reset, low
  input wire logic        psel,            // Select
  input wire logic        penable,         // Access
  input wire logic        pwrite,          // Write
  input wire logic [7:0]  paddr,           // Address
  input wire logic [31:0] pwdata,          // Write data
  input wire logic        pready,          // Ready
  input wire logic        pslverr,         // Error
  input wire logic [2:0]  irq_ack,         // Taken
  input wire logic [2:0]  irq_req,         // Requests
  input wire logic        port_out_a,      // Port A
  input wire logic        port_dir_a,      // Dir A
  input wire logic        port_out_b,      // Port B
  input wire logic        port_dir_b,      // Dir B
  input wire logic        cmp_output_a,    // Pin A
  input wire logic        cmp_output_a_oe, // Enable A
  input wire logic        cmp_output_b,    // Pin B
  input wire logic        cmp_output_b_oe  // Enable B
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ca;
  logic [3:0] cb;
  logic [2:0] mk;
  wire        acc = psel && penable && pwrite && pready;

  // Shadow of fields the outputs depend on, kept from bus writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ca <= 8'h00;
      cb <= 4'h0;
      mk <= 3'h0;
    end
    else if (acc && paddr == tmr_pkg::OFS_CTRL_A)
      ca <= pwdata[7:0];
    else if (acc && paddr == tmr_pkg::OFS_CTRL_B)
      cb <= pwdata[3:0];
    else if (acc && paddr == tmr_pkg::OFS_MASK)
      mk <= pwdata[2:0];
  end

  // One clock domain, so defaults keep each property short
  default clocking dclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wr(a);
    acc && paddr == a;
  endsequence
  // Forced toggle in a non-PWM mode, any tick source
  sequence s_force;
    s_wr(tmr_pkg::OFS_CTRL_C) ##0 (pwdata[7] && !ca[0]
      && ca[7:6] == tmr_pkg::COM_TOGGLE);
  endsequence

  property p_oe;
    cmp_output_a_oe == port_dir_a && cmp_output_b_oe == port_dir_b;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pass_a;
    ca[7:6] == 2'h0 |-> cmp_output_a == port_out_a;
  endproperty
  a_pass_a: assert property (p_pass_a) else $error("pin A wrong");
  property p_pass_b;
    ca[5:4] == 2'h0 |-> cmp_output_b == port_out_b;
  endproperty
  a_pass_b: assert property (p_pass_b) else $error("pin B wrong");
  property p_rst;
    $rose(presetn) |-> irq_req == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("request after reset");
  property p_mask;
    (irq_req & ~mk) == 3'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request");
  // Ticks stopped, so nothing can set a flag again behind the ack
  property p_ack;
    cb[2:0] == 3'h0 |=> (irq_req & $past(irq_ack)) == 3'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("ack kept flag");
  property p_w1c;
    s_wr(tmr_pkg::OFS_FLAG) ##0 cb[2:0] == 3'h0
      |=> (irq_req & $past(pwdata[2:0])) == 3'h0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_force;
    s_force |-> ##[1:2] $changed(cmp_output_a);
  endproperty
  a_force: assert property (p_force) else $error("force no toggle");
  property p_err;
    psel && penable && paddr >= 8'h20 |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no slave error");
endmodule : tmr_chk

bind tmr_core tmr_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .irq_ack, .irq_req, .port_out_a,
  .port_dir_a, .port_out_b, .port_dir_b, .cmp_output_a, .cmp_output_a_oe,
  .cmp_output_b, .cmp_output_b_oe);

// ==== bench/testbench.sv ====
// Self-checking bench for the timer core.
// Assumes zero-wait APB; ticks come from prescaler tap 0, and in the last case from the count pin.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [31:0] d;
                         logic [7:0] e;} tmr_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic [3:0]  presc_tap = 4'h0;
  logic [2:0]  irq_ack = 3'h0;
  logic [2:0]  irq_req;
  logic        port_dir_b = 1'b0;
  logic        oa;
  logic        ext_pin = 1'b0;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  tmr_row_t    rows [6] = '{'{8'h0c, 32'h5a, 8'h5a}, '{8'h10, 32'h1a5, 8'ha5},
    '{8'h14, 32'h3c, 8'h3c}, '{8'h1c, 32'hff, 8'h07},
    '{8'h08, 32'h0, 8'h00}, '{8'h20, 32'h55, 8'h00}};
  logic [7:0]  rst_a [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  tmr_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(), .presc_tap(presc_tap),
    .ext_count_pin(ext_pin), .irq_ack(irq_ack), .irq_req(irq_req),
    .port_out_a(1'b1), .port_dir_a(1'b1), .port_out_b(1'b0),
    .port_dir_b(port_dir_b), .cmp_output_a(oa), .cmp_output_a_oe(),
    .cmp_output_b(), .cmp_output_b_oe());

  // Clock and hang guard
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // One APB transfer; the leading edge keeps releases and setups apart
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a, e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(n, r, {24'h0, e});
  endtask : rd_chk

  // Single tick from prescaler tap 0
  task automatic tap();
    @(posedge pclk);
    presc_tap <= 4'h1;
    @(posedge pclk);
    presc_tap <= 4'h0;
  endtask : tap

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // Main sequence: reset, table rows, then the awkward cases
  initial
  begin
    repeat (10) @(posedge pclk);
    check("pin_a_rst", oa, 1'b1);
    presetn <= 1'b1;
    port_dir_b <= 1'b1;
    foreach (rst_a[i])
      rd_chk("reset", rst_a[i], 8'h00);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd_chk("row", rows[i].a, rows[i].e);
    end
    repeat (5) @(posedge pclk);
    rd_chk("stopped", tmr_pkg::OFS_COUNT, 8'h5a);
    // Count write equal to compare B hides that match
    wr(tmr_pkg::OFS_CMP_A, 32'hff);
    wr(tmr_pkg::OFS_CMP_B, 32'h10);
    wr(tmr_pkg::OFS_COUNT, 32'h10);
    wr(tmr_pkg::OFS_FLAG, 32'h7);
    wr(tmr_pkg::OFS_CTRL_B, 32'h2);
    tap();
    repeat (2) @(posedge pclk);
    check("blocked", irq_req, 3'h0);
    rd_chk("count", tmr_pkg::OFS_COUNT, 8'h11);
    wr(tmr_pkg::OFS_COUNT, 32'hfe);
    tap();
    tap();
    repeat (2) @(posedge pclk);
    check("ovf_match", irq_req, 3'h3);
    rd_chk("wrap", tmr_pkg::OFS_COUNT, 8'h00);
    wr(tmr_pkg::OFS_CTRL_B, 32'h0);
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    @(posedge pclk);
    check("ack", irq_req, 3'h2);
    wr(tmr_pkg::OFS_FLAG, 32'h2);
    @(posedge pclk);
    check("w1c", irq_req, 3'h0);
    // Toggle mode shows the state, then a forced match flips it
    wr(tmr_pkg::OFS_CTRL_A, 32'h40);
    @(posedge pclk);
    check("override", oa, 1'b0);
    wr(tmr_pkg::OFS_CTRL_C, 32'h80);
    repeat (2) @(posedge pclk);
    check("force", oa, 1'b1);
    check("force_flag", irq_req, 3'h0);
    wr(tmr_pkg::OFS_CTRL_A, 32'h43);
    @(posedge pclk);
    check("mode_keep", oa, 1'b1);
    // Mid-run reset clears compare values and the output state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("rst2_cmp", tmr_pkg::OFS_CMP_A, 8'h00);
    wr(tmr_pkg::OFS_CTRL_A, 32'h40);
    @(posedge pclk);
    check("rst2_state", oa, 1'b0);
    // One rising edge on the count pin gives exactly one tick
    wr(tmr_pkg::OFS_COUNT, 32'h20);
    wr(tmr_pkg::OFS_CTRL_B, 32'h7);
    ext_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    wr(tmr_pkg::OFS_CTRL_B, 32'h0);
    rd_chk("ext_tick", tmr_pkg::OFS_COUNT, 8'h21);
    print_verdict();
  end
endmodule : testbench
